// ===== hw/mpb_cfg.svh
// offsets, field layouts, reset values and timing figures of the motion parameter bank
`ifndef MPB_CFG_SVH
`define MPB_CFG_SVH

// object indices and highest subindex answers
`define MPB_IDX_JERK 16'h60A4
`define MPB_IDX_POS_UNIT 16'h60A8
`define MPB_IDX_VEL_UNIT 16'h60A9
`define MPB_IDX_POS_OFF 16'h60B0
`define MPB_IDX_VEL_OFF 16'h60B1
`define MPB_IDX_TRQ_OFF 16'h60B2
`define MPB_IDX_INTERP_REC 16'h60C1
`define MPB_IDX_INTERP_PER 16'h60C2
`define MPB_JERK_TOP_SUB 8'h04
`define MPB_REC_TOP_SUB 8'h01
`define MPB_PER_TOP_SUB 8'h02
`define MPB_SUB_00 8'h00
`define MPB_SUB_01 8'h01
`define MPB_SUB_02 8'h02

// unit word fields: position word keeps 31:16, velocity word keeps 31:8
`define MPB_POS_UNIT_MASK 32'hFFFF0000
`define MPB_VEL_UNIT_MASK 32'hFFFFFF00

// reset values
`define MPB_JERK_RST 32'h000003E8
`define MPB_POS_UNIT_RST 32'hFF410000
`define MPB_VEL_UNIT_RST 32'h00B44700
`define MPB_OFF32_RST 32'h00000000
`define MPB_OFF16_RST 16'h0000
`define MPB_REC_RST 32'h00000000
`define MPB_PER_VAL_RST 8'h01
`define MPB_PER_IDX 8'hFD

// timing: one millisecond at the core clock
`define MPB_MS_NS 1000000
`define MPB_CLK_PERIOD_NS 8

`endif

// ===== hw/mpb_pkg.sv
// types shared by the motion parameter bank
package mpb_pkg;

  // active operating mode as reported by the drive core
  typedef enum logic [2:0] {
    MPB_MODE_OTHER,
    MPB_MODE_CSP,
    MPB_MODE_CSV,
    MPB_MODE_CST,
    MPB_MODE_STEPDIR
  } mpb_mode_t;

  // ramp segment the ramp generator is entering
  typedef enum logic [1:0] {
    MPB_RAMP_ACC_BEGIN,
    MPB_RAMP_BRK_BEGIN,
    MPB_RAMP_ACC_END,
    MPB_RAMP_BRK_END
  } mpb_ramp_t;

endpackage

// ===== hw/mpb_period_timer.sv
// interpolation period timer: one tick every period value milliseconds
`timescale 1ns/100ps
module mpb_period_timer #(
  parameter int CYC_PER_MS = 125000
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // period in milliseconds, zero stops the ticks
  input wire logic [7:0] i_period,
  // one-cycle pulse at each period end
  output logic o_tick
);

  localparam int MSW = $clog2(CYC_PER_MS);

  logic [MSW-1:0] ms_cnt_r, ms_cnt_nxt;
  logic [7:0] per_cnt_r, per_cnt_nxt;
  logic tick_r, tick_nxt;
  logic ms_en;

  // millisecond enable divider, then count whole milliseconds
  always_comb
  begin
    ms_en = (ms_cnt_r == MSW'(CYC_PER_MS - 1));
    ms_cnt_nxt = ms_en ? '0 : MSW'(ms_cnt_r + 1'b1);
    per_cnt_nxt = per_cnt_r;
    tick_nxt = 1'b0;
    if (i_period == 8'h00)
    begin
      per_cnt_nxt = 8'h00;
    end
    else if (ms_en)
    begin
      // >= so a shortened period never lets the counter run past it
      if (8'(per_cnt_r + 8'h01) >= i_period)
      begin
        per_cnt_nxt = 8'h00;
        tick_nxt = 1'b1;
      end
      else
      begin
        per_cnt_nxt = 8'(per_cnt_r + 8'h01);
      end
    end
  end

  // registers only
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      ms_cnt_r <= '0;
      per_cnt_r <= 8'h00;
      tick_r <= 1'b0;
    end
    else
    begin
      ms_cnt_r <= ms_cnt_nxt;
      per_cnt_r <= per_cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign o_tick = tick_r;

endmodule

// ===== hw/mpb_param_bank.sv
// motion profile parameter bank: object access port, jerk select, setpoint offsets
//
// Behaviour
// - begin jerks: sub 01 accel, sub 02 brake
// - end jerks: sub 03 accel, sub 04 brake
// - position unit word fields, reset FF410000
// - velocity unit word fields, reset 00B44700
// - position offset only in CSP, step/dir
// - velocity offset in CSP, CSV, step/dir
// - torque offset in cyclic modes, step/dir
// - demand position effective at next sync
// - zero jerk means jerk not limited
// - period index must be -3, milliseconds
`include "mpb_cfg.svh"
`timescale 1ns/100ps
module mpb_param_bank #(
  parameter int CYC_PER_MS = `MPB_MS_NS / `MPB_CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // object access from the fieldbus side
  input wire logic i_od_req,
  input wire logic i_od_wr,
  input wire logic [15:0] i_od_index,
  input wire logic [7:0] i_od_subidx,
  input wire logic [31:0] i_od_wdata,
  output logic o_od_ack,
  output logic o_od_err,
  output logic [31:0] o_od_rdata,
  // synchronisation pin, asynchronous
  input wire logic i_sync,
  // drive core state
  input wire mpb_pkg::mpb_mode_t i_mode,
  input wire mpb_pkg::mpb_ramp_t i_ramp_phase,
  input wire logic [31:0] i_pos_setpoint,
  input wire logic [31:0] i_vel_setpoint,
  input wire logic [15:0] i_trq_setpoint,
  // jerk for the current ramp segment
  output logic [31:0] o_jerk_value,
  output logic o_jerk_limited,
  // setpoints with offsets applied
  output logic [31:0] o_pos_setpoint,
  output logic [31:0] o_vel_setpoint,
  output logic [15:0] o_trq_setpoint,
  // interpolation
  output logic [31:0] o_interp_target,
  output logic o_interp_tick
);

  // mode sets that take each offset
  function automatic logic pos_off_mode(input mpb_pkg::mpb_mode_t m);
    pos_off_mode = (m == mpb_pkg::MPB_MODE_CSP) || (m == mpb_pkg::MPB_MODE_STEPDIR);
  endfunction

  function automatic logic vel_off_mode(input mpb_pkg::mpb_mode_t m);
    vel_off_mode = pos_off_mode(m) || (m == mpb_pkg::MPB_MODE_CSV);
  endfunction

  function automatic logic trq_off_mode(input mpb_pkg::mpb_mode_t m);
    trq_off_mode = vel_off_mode(m) || (m == mpb_pkg::MPB_MODE_CST);
  endfunction

  logic [31:0] jerk_r [4];
  logic [31:0] jerk_nxt [4];
  logic [31:0] pos_unit_r, pos_unit_nxt;
  logic [31:0] vel_unit_r, vel_unit_nxt;
  logic [31:0] pos_off_r, pos_off_nxt;
  logic [31:0] vel_off_r, vel_off_nxt;
  logic [15:0] trq_off_r, trq_off_nxt;
  logic [31:0] staged_r, staged_nxt;
  logic [7:0] per_val_r, per_val_nxt;
  logic ack_r, ack_nxt;
  logic err_r, err_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic wr, rd;
  logic [1:0] jsel;

  // object dictionary decode: reads answer, writes update the next values
  always_comb
  begin
    jerk_nxt = jerk_r;
    pos_unit_nxt = pos_unit_r;
    vel_unit_nxt = vel_unit_r;
    pos_off_nxt = pos_off_r;
    vel_off_nxt = vel_off_r;
    trq_off_nxt = trq_off_r;
    staged_nxt = staged_r;
    per_val_nxt = per_val_r;
    ack_nxt = i_od_req;
    err_nxt = 1'b0;
    rdata_nxt = 32'h00000000;
    wr = i_od_req & i_od_wr;
    rd = i_od_req & ~i_od_wr;
    jsel = 2'(i_od_subidx - `MPB_SUB_01);
    case (i_od_index)
      `MPB_IDX_JERK:
      begin
        if (i_od_subidx == `MPB_SUB_00)
        begin
          err_nxt = wr;
          rdata_nxt = rd ? {24'h000000, `MPB_JERK_TOP_SUB} : 32'h00000000;
        end
        else if (i_od_subidx <= `MPB_JERK_TOP_SUB)
        begin
          if (wr)
          begin
            jerk_nxt[jsel] = i_od_wdata;
          end
          rdata_nxt = rd ? jerk_r[jsel] : 32'h00000000;
        end
        else
        begin
          err_nxt = i_od_req;
        end
      end
      `MPB_IDX_POS_UNIT:
      begin
        if (wr)
        begin
          pos_unit_nxt = i_od_wdata & `MPB_POS_UNIT_MASK;
        end
        rdata_nxt = rd ? pos_unit_r : 32'h00000000;
      end
      `MPB_IDX_VEL_UNIT:
      begin
        if (wr)
        begin
          vel_unit_nxt = i_od_wdata & `MPB_VEL_UNIT_MASK;
        end
        rdata_nxt = rd ? vel_unit_r : 32'h00000000;
      end
      `MPB_IDX_POS_OFF:
      begin
        if (wr)
        begin
          pos_off_nxt = i_od_wdata;
        end
        rdata_nxt = rd ? pos_off_r : 32'h00000000;
      end
      `MPB_IDX_VEL_OFF:
      begin
        if (wr)
        begin
          vel_off_nxt = i_od_wdata;
        end
        rdata_nxt = rd ? vel_off_r : 32'h00000000;
      end
      `MPB_IDX_TRQ_OFF:
      begin
        if (wr)
        begin
          trq_off_nxt = i_od_wdata[15:0];
        end
        rdata_nxt = rd ? {16'h0000, trq_off_r} : 32'h00000000;
      end
      `MPB_IDX_INTERP_REC:
      begin
        if (i_od_subidx == `MPB_SUB_00)
        begin
          err_nxt = wr;
          rdata_nxt = rd ? {24'h000000, `MPB_REC_TOP_SUB} : 32'h00000000;
        end
        else if (i_od_subidx == `MPB_SUB_01)
        begin
          if (wr)
          begin
            staged_nxt = i_od_wdata;
          end
          rdata_nxt = rd ? staged_r : 32'h00000000;
        end
        else
        begin
          err_nxt = i_od_req;
        end
      end
      `MPB_IDX_INTERP_PER:
      begin
        if (i_od_subidx == `MPB_SUB_00)
        begin
          err_nxt = wr;
          rdata_nxt = rd ? {24'h000000, `MPB_PER_TOP_SUB} : 32'h00000000;
        end
        else if (i_od_subidx == `MPB_SUB_01)
        begin
          if (wr)
          begin
            per_val_nxt = i_od_wdata[7:0];
          end
          rdata_nxt = rd ? {24'h000000, per_val_r} : 32'h00000000;
        end
        else if (i_od_subidx == `MPB_SUB_02)
        begin
          // only the millisecond base exists, so the index is a fixed value
          err_nxt = wr && (i_od_wdata[7:0] != `MPB_PER_IDX);
          rdata_nxt = rd ? {24'h000000, `MPB_PER_IDX} : 32'h00000000;
        end
        else
        begin
          err_nxt = i_od_req;
        end
      end
      default:
      begin
        err_nxt = i_od_req;
      end
    endcase
  end

  // parameter registers
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      for (int i = 0; i < 4; i++)
      begin
        jerk_r[i] <= `MPB_JERK_RST;
      end
      pos_unit_r <= `MPB_POS_UNIT_RST;
      vel_unit_r <= `MPB_VEL_UNIT_RST;
      pos_off_r <= `MPB_OFF32_RST;
      vel_off_r <= `MPB_OFF32_RST;
      trq_off_r <= `MPB_OFF16_RST;
      staged_r <= `MPB_REC_RST;
      per_val_r <= `MPB_PER_VAL_RST;
      ack_r <= 1'b0;
      err_r <= 1'b0;
      rdata_r <= 32'h00000000;
    end
    else
    begin
      jerk_r <= jerk_nxt;
      pos_unit_r <= pos_unit_nxt;
      vel_unit_r <= vel_unit_nxt;
      pos_off_r <= pos_off_nxt;
      vel_off_r <= vel_off_nxt;
      trq_off_r <= trq_off_nxt;
      staged_r <= staged_nxt;
      per_val_r <= per_val_nxt;
      ack_r <= ack_nxt;
      err_r <= err_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  logic sync_meta_r, sync_s2_r, sync_s3_r;
  logic [31:0] target_r, target_nxt;
  logic sync_edge;

  // sync pin: two flops, then rising edge; a write in the edge cycle waits for the next sync
  always_comb
  begin
    sync_edge = sync_s2_r & ~sync_s3_r;
    target_nxt = sync_edge ? staged_r : target_r;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      sync_meta_r <= 1'b0;
      sync_s2_r <= 1'b0;
      sync_s3_r <= 1'b0;
      target_r <= `MPB_REC_RST;
    end
    else
    begin
      sync_meta_r <= i_sync;
      sync_s2_r <= sync_meta_r;
      sync_s3_r <= sync_s2_r;
      target_r <= target_nxt;
    end
  end

  logic [31:0] jerk_out_r, jerk_out_nxt;
  logic limited_r, limited_nxt;
  logic [31:0] pos_sp_r, pos_sp_nxt;
  logic [31:0] vel_sp_r, vel_sp_nxt;
  logic [15:0] trq_sp_r, trq_sp_nxt;

  // jerk pick per segment and setpoint offsets, registered for the drive core
  always_comb
  begin
    unique case (i_ramp_phase)
      mpb_pkg::MPB_RAMP_ACC_BEGIN: jerk_out_nxt = jerk_r[0];
      mpb_pkg::MPB_RAMP_BRK_BEGIN: jerk_out_nxt = jerk_r[1];
      mpb_pkg::MPB_RAMP_ACC_END: jerk_out_nxt = jerk_r[2];
      mpb_pkg::MPB_RAMP_BRK_END: jerk_out_nxt = jerk_r[3];
    endcase
    limited_nxt = (jerk_out_nxt != 32'h00000000);
    pos_sp_nxt = i_pos_setpoint + (pos_off_mode(i_mode) ? pos_off_r : 32'h00000000);
    vel_sp_nxt = i_vel_setpoint + (vel_off_mode(i_mode) ? vel_off_r : 32'h00000000);
    trq_sp_nxt = i_trq_setpoint + (trq_off_mode(i_mode) ? trq_off_r : 16'h0000);
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      jerk_out_r <= 32'h00000000;
      limited_r <= 1'b0;
      pos_sp_r <= 32'h00000000;
      vel_sp_r <= 32'h00000000;
      trq_sp_r <= 16'h0000;
    end
    else
    begin
      jerk_out_r <= jerk_out_nxt;
      limited_r <= limited_nxt;
      pos_sp_r <= pos_sp_nxt;
      vel_sp_r <= vel_sp_nxt;
      trq_sp_r <= trq_sp_nxt;
    end
  end

  // interpolation cycle = period value in milliseconds
  mpb_period_timer #(
    .CYC_PER_MS(CYC_PER_MS)
  ) u_timer (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_period(per_val_r),
    .o_tick(o_interp_tick)
  );

  assign o_od_ack = ack_r;
  assign o_od_err = err_r;
  assign o_od_rdata = rdata_r;
  assign o_jerk_value = jerk_out_r;
  assign o_jerk_limited = limited_r;
  assign o_pos_setpoint = pos_sp_r;
  assign o_vel_setpoint = vel_sp_r;
  assign o_trq_setpoint = trq_sp_r;
  assign o_interp_target = target_r;

  // checks beside the logic
  property p_begin_jerk;
    @(posedge i_core_clk) disable iff (i_srst)
    (i_ramp_phase == mpb_pkg::MPB_RAMP_BRK_BEGIN) |=> (o_jerk_value == $past(jerk_r[1]));
  endproperty
  a_begin_jerk: assert property (p_begin_jerk) else $error("brake begin jerk wrong");

  property p_end_jerk;
    @(posedge i_core_clk) disable iff (i_srst)
    (i_ramp_phase == mpb_pkg::MPB_RAMP_ACC_END) |=> (o_jerk_value == $past(jerk_r[2]));
  endproperty
  a_end_jerk: assert property (p_end_jerk) else $error("accel end jerk wrong");

  property p_pos_unit;
    @(posedge i_core_clk)
    $fell(i_srst) |-> (pos_unit_r == `MPB_POS_UNIT_RST) && (vel_unit_r == `MPB_VEL_UNIT_RST);
  endproperty
  a_pos_unit: assert property (p_pos_unit) else $error("unit word reset wrong");

  property p_reserved;
    @(posedge i_core_clk) disable iff (i_srst)
    (pos_unit_r[15:0] == 16'h0000) && (vel_unit_r[7:0] == 8'h00);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved unit bits set");

  property p_pos_off;
    @(posedge i_core_clk) disable iff (i_srst)
    !pos_off_mode(i_mode) |=> (o_pos_setpoint == $past(i_pos_setpoint));
  endproperty
  a_pos_off: assert property (p_pos_off) else $error("position offset outside mode");

  property p_vel_off;
    @(posedge i_core_clk) disable iff (i_srst)
    (i_mode == mpb_pkg::MPB_MODE_CSV) |=> (o_vel_setpoint == $past(i_vel_setpoint + vel_off_r));
  endproperty
  a_vel_off: assert property (p_vel_off) else $error("velocity offset missing");

  property p_trq_off;
    @(posedge i_core_clk) disable iff (i_srst)
    (i_mode == mpb_pkg::MPB_MODE_OTHER) |=> (o_trq_setpoint == $past(i_trq_setpoint));
  endproperty
  a_trq_off: assert property (p_trq_off) else $error("torque offset outside mode");

  property p_latch_at_sync;
    @(posedge i_core_clk) disable iff (i_srst)
    !sync_edge ##1 !sync_edge |-> $stable(o_interp_target);
  endproperty
  a_latch_at_sync: assert property (p_latch_at_sync) else $error("target moved without sync");

  property p_jerk_zero;
    @(posedge i_core_clk) disable iff (i_srst)
    o_jerk_limited == (o_jerk_value != 32'h00000000);
  endproperty
  a_jerk_zero: assert property (p_jerk_zero) else $error("jerk limit flag wrong");

  property p_per_index;
    @(posedge i_core_clk) disable iff (i_srst)
    (wr && i_od_index == `MPB_IDX_INTERP_PER && i_od_subidx == `MPB_SUB_02
      && i_od_wdata[7:0] != `MPB_PER_IDX) |=> o_od_ack && o_od_err;
  endproperty
  a_per_index: assert property (p_per_index) else $error("bad period index accepted");

endmodule

// ===== verif/mpb_master_model.sv
// fieldbus master model: object requests and synchronisation pulses
`timescale 1ns/100ps
module mpb_master_model (
  // clock
  input wire logic i_core_clk,
  // object port towards the bank
  output logic o_od_req,
  output logic o_od_wr,
  output logic [15:0] o_od_index,
  output logic [7:0] o_od_subidx,
  output logic [31:0] o_od_wdata,
  input wire logic i_od_ack,
  input wire logic i_od_err,
  input wire logic [31:0] i_od_rdata,
  // synchronisation pin
  output logic o_sync
);
  // idle bus at time zero
  initial
  begin
    o_od_req = 1'b0;
    o_od_wr = 1'b0;
    o_od_index = 16'h0000;
    o_od_subidx = 8'h00;
    o_od_wdata = 32'h00000000;
    o_sync = 1'b0;
  end

  // one-cycle request; err comes back unknown when no ack arrived
  task automatic access(input logic w, input logic [15:0] idx, input logic [7:0] sub,
    input logic [31:0] wd, output logic [31:0] rd, output logic er);
    @(posedge i_core_clk);
    o_od_req <= 1'b1;
    o_od_wr <= w;
    o_od_index <= idx;
    o_od_subidx <= sub;
    o_od_wdata <= wd;
    @(posedge i_core_clk);
    o_od_req <= 1'b0;
    // released index and data lines show the inverse, so a stale value is never taken as fresh
    o_od_index <= ~idx;
    o_od_wdata <= ~wd;
    #1;
    rd = i_od_rdata;
    er = (i_od_ack === 1'b1) ? i_od_err : 1'bx;
  endtask

  // sync pulse with two cycles high and two low
  task automatic sync_pulse;
    @(posedge i_core_clk);
    o_sync <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    o_sync <= 1'b0;
    repeat (2) @(posedge i_core_clk);
  endtask
endmodule

// ===== verif/mpb_param_bank_tb_top.sv
// self-checking bench of the motion parameter bank
`include "mpb_cfg.svh"
`timescale 1ns/100ps
module mpb_param_bank_tb_top;
  // short millisecond keeps period checks fast
  localparam int CYC = 10;
  logic i_core_clk = 1'b0;
  logic i_srst = 1'b1;
  logic req, wr, ack, err, sync, limited, tick;
  logic [15:0] idx;
  logic [7:0] sub;
  logic [31:0] wd, rd, jerk, pos_o, vel_o, tgt;
  logic [31:0] pos_i = 32'h10000000;
  logic [31:0] vel_i = 32'h00000100;
  logic [15:0] trq_i = 16'h0010;
  logic [15:0] trq_o;
  mpb_pkg::mpb_mode_t mode = mpb_pkg::MPB_MODE_OTHER;
  mpb_pkg::mpb_ramp_t ramp = mpb_pkg::MPB_RAMP_ACC_BEGIN;
  int err_total = 0;
  int comparisons = 0;

  // 125 MHz clock
  always #4 i_core_clk = ~i_core_clk;

  mpb_master_model m (.i_core_clk(i_core_clk), .o_od_req(req), .o_od_wr(wr),
    .o_od_index(idx), .o_od_subidx(sub), .o_od_wdata(wd), .i_od_ack(ack),
    .i_od_err(err), .i_od_rdata(rd), .o_sync(sync));

  mpb_param_bank #(.CYC_PER_MS(CYC)) dut (.i_core_clk(i_core_clk), .i_srst(i_srst),
    .i_od_req(req), .i_od_wr(wr), .i_od_index(idx), .i_od_subidx(sub), .i_od_wdata(wd),
    .o_od_ack(ack), .o_od_err(err), .o_od_rdata(rd), .i_sync(sync), .i_mode(mode),
    .i_ramp_phase(ramp), .i_pos_setpoint(pos_i), .i_vel_setpoint(vel_i),
    .i_trq_setpoint(trq_i), .o_jerk_value(jerk), .o_jerk_limited(limited),
    .o_pos_setpoint(pos_o), .o_vel_setpoint(vel_o), .o_trq_setpoint(trq_o),
    .o_interp_target(tgt), .o_interp_tick(tick));

  task automatic finish_test;
    if (err_total == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one access, answer data and refusal flag both judged
  task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s,
    input logic [31:0] d, input logic [31:0] exp, input logic e);
    logic [31:0] r;
    logic x;
    m.access(w, i, s, d, r, x);
    chk("od_rdata", r, exp);
    chk("od_err", {31'h0, x}, {31'h0, e});
  endtask

  // let one edge land, then look at settled outputs
  task automatic settle;
    @(posedge i_core_clk);
    #1;
  endtask

  task automatic t_reset;
    for (int s = 1; s <= 4; s++)
      acc(1'b0, `MPB_IDX_JERK, 8'(s), 32'h0, 32'h000003E8, 1'b0);
    acc(1'b0, `MPB_IDX_JERK, 8'h00, 32'h0, 32'h00000004, 1'b0);
    acc(1'b0, `MPB_IDX_POS_UNIT, 8'h00, 32'h0, 32'hFF410000, 1'b0);
    acc(1'b0, `MPB_IDX_VEL_UNIT, 8'h00, 32'h0, 32'h00B44700, 1'b0);
    acc(1'b0, `MPB_IDX_POS_OFF, 8'h00, 32'h0, 32'h00000000, 1'b0);
    acc(1'b0, `MPB_IDX_VEL_OFF, 8'h00, 32'h0, 32'h00000000, 1'b0);
    acc(1'b0, `MPB_IDX_TRQ_OFF, 8'h00, 32'h0, 32'h00000000, 1'b0);
    acc(1'b0, `MPB_IDX_INTERP_REC, 8'h01, 32'h0, 32'h00000000, 1'b0);
    acc(1'b0, `MPB_IDX_INTERP_PER, 8'h01, 32'h0, 32'h00000001, 1'b0);
  endtask

  task automatic t_units;
    acc(1'b1, `MPB_IDX_POS_UNIT, 8'h00, 32'hFFFFFFFF, 32'h0, 1'b0);
    acc(1'b0, `MPB_IDX_POS_UNIT, 8'h00, 32'h0, 32'hFFFF0000, 1'b0);
    acc(1'b1, `MPB_IDX_VEL_UNIT, 8'h00, 32'h123456FF, 32'h0, 1'b0);
    acc(1'b0, `MPB_IDX_VEL_UNIT, 8'h00, 32'h0, 32'h12345600, 1'b0);
  endtask

  task automatic t_jerk;
    for (int s = 1; s <= 4; s++)
      acc(1'b1, `MPB_IDX_JERK, 8'(s), 32'h00000100 + 32'(s), 32'h0, 1'b0);
    acc(1'b1, `MPB_IDX_JERK, 8'h05, 32'h1, 32'h0, 1'b1);
    for (int p = 0; p < 4; p++)
    begin
      @(posedge i_core_clk);
      ramp <= mpb_pkg::mpb_ramp_t'(p);
      settle;
      chk("jerk_value", jerk, 32'h00000101 + 32'(p));
    end
    // zero in the accel begin entry switches limiting off for that segment only
    acc(1'b1, `MPB_IDX_JERK, 8'h01, 32'h0, 32'h0, 1'b0);
    @(posedge i_core_clk);
    ramp <= mpb_pkg::MPB_RAMP_ACC_BEGIN;
    settle;
    chk("jerk_limited", {31'h0, limited}, 32'h0);
    @(posedge i_core_clk);
    ramp <= mpb_pkg::MPB_RAMP_BRK_BEGIN;
    settle;
    chk("jerk_limited", {31'h0, limited}, 32'h1);
  endtask

  task automatic t_offsets;
    mpb_pkg::mpb_mode_t md;
    acc(1'b1, `MPB_IDX_POS_OFF, 8'h00, 32'hFFFFFFF0, 32'h0, 1'b0);
    acc(1'b1, `MPB_IDX_VEL_OFF, 8'h00, 32'h00000005, 32'h0, 1'b0);
    acc(1'b1, `MPB_IDX_TRQ_OFF, 8'h00, 32'h1234FFFF, 32'h0, 1'b0);
    acc(1'b0, `MPB_IDX_TRQ_OFF, 8'h00, 32'h0, 32'h0000FFFF, 1'b0);
    for (int k = 0; k < 5; k++)
    begin
      md = mpb_pkg::mpb_mode_t'(k);
      @(posedge i_core_clk);
      mode <= md;
      settle;
      chk("pos_setpoint", pos_o, pos_i + ((md == mpb_pkg::MPB_MODE_CSP ||
        md == mpb_pkg::MPB_MODE_STEPDIR) ? 32'hFFFFFFF0 : 32'h0));
      chk("vel_setpoint", vel_o, vel_i + ((md == mpb_pkg::MPB_MODE_CSP ||
        md == mpb_pkg::MPB_MODE_CSV || md == mpb_pkg::MPB_MODE_STEPDIR) ? 32'h5 : 32'h0));
      chk("trq_setpoint", {16'h0, trq_o},
        {16'h0, trq_i + ((md != mpb_pkg::MPB_MODE_OTHER) ? 16'hFFFF : 16'h0)});
    end
  endtask

  task automatic t_sync;
    int n;
    acc(1'b1, `MPB_IDX_INTERP_REC, 8'h01, 32'h12345678, 32'h0, 1'b0);
    repeat (4) settle;
    chk("interp_target", tgt, 32'h0);
    m.sync_pulse;
    n = 0;
    while (tgt !== 32'h12345678 && n < 8)
    begin
      settle;
      n++;
    end
    chk("interp_target", tgt, 32'h12345678);
    // a sync that never lands ends the run here, already counted above
    if (n >= 8)
      finish_test;
    acc(1'b1, `MPB_IDX_INTERP_REC, 8'h01, 32'h0000AA55, 32'h0, 1'b0);
    repeat (6) settle;
    chk("interp_target", tgt, 32'h12345678);
  endtask

  // cycles up to the next tick, bounded
  task automatic gap(output int n);
    n = 0;
    do
    begin
      settle;
      n++;
    end while (tick !== 1'b1 && n < 200);
    if (n >= 200)
    begin
      chk("tick_timeout", 32'h0, 32'h1);
      finish_test;
    end
  endtask

  task automatic t_period;
    int n;
    acc(1'b1, `MPB_IDX_INTERP_PER, 8'h02, 32'h00000000, 32'h0, 1'b1);
    acc(1'b1, `MPB_IDX_INTERP_PER, 8'h02, 32'h000000FD, 32'h0, 1'b0);
    acc(1'b0, `MPB_IDX_INTERP_PER, 8'h02, 32'h0, 32'h000000FD, 1'b0);
    acc(1'b0, 16'h6000, 8'h00, 32'h0, 32'h0, 1'b1);
    acc(1'b1, `MPB_IDX_INTERP_PER, 8'h01, 32'h00000003, 32'h0, 1'b0);
    gap(n);
    gap(n);
    gap(n);
    chk("tick_gap", 32'(n), 32'(3 * CYC));
  endtask

  // reset for five cycles, then every scenario in turn
  initial
  begin
    repeat (5) @(posedge i_core_clk);
    i_srst <= 1'b0;
    t_reset;
    t_units;
    t_jerk;
    t_offsets;
    t_sync;
    t_period;
    finish_test;
  end
endmodule
